// [rtl/ssq_sequencer.sv]
// Purpose: sequencer for string move, translating move and string compare
// Assumes: bus interface answers one request at a time with mem_ack
// Notes:   registers r0..r4 are loaded at start, r0..r2 written back at end
`timescale 1ns/1ps
`default_nettype none
module ssq_sequencer
  import ssq_pkg::*;
#(
  parameter int unsigned ADDR_W = 32
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // instruction start and register file values
  input  wire logic        start,
  input  wire ssq_cmd_t    cmd,
  input  wire logic [31:0] reg_count,
  input  wire logic [31:0] reg_ptr1,
  input  wire logic [31:0] reg_ptr2,
  input  wire logic [31:0] reg_table,
  input  wire logic [31:0] reg_cmpval,
  // memory interface
  output logic             mem_req,
  output ssq_mreq_t        mem_cmd,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  // completion and register write-back
  output logic             busy,
  output logic             done,
  output ssq_end_t         end_cause,
  output logic             cmp_equal,
  output logic [31:0]      wb_count,
  output logic [31:0]      wb_ptr1,
  output logic [31:0]      wb_ptr2
);

  // refused at elaboration: only a 32-bit address path is served
  if (ADDR_W != 32) begin : g_addr_check
    $error("ssq_sequencer: only 32-bit addresses served");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_CHECK, ST_RD1, ST_RD2, ST_XLAT, ST_WR, ST_ADV
  } ssq_state_t;

  ssq_state_t  st_q, st_d;
  ssq_cmd_t    cmd_q, cmd_d;
  logic [31:0] cnt_q, cnt_d, p1_q, p1_d, p2_q, p2_d;
  logic [31:0] tbl_q, tbl_d, cv_q, cv_d, e1_q, e1_d;
  logic        req_q, req_d, done_q, done_d, eq_q, eq_d, busy_q, busy_d;
  ssq_mreq_t   mc_q, mc_d;
  ssq_end_t    end_q, end_d;
  logic [31:0] step, mask, e1m, cvm, rdm;

  // element width as a byte step and a data mask
  always_comb begin
    case (cmd_q.size)
      SZ_BYTE:  begin step = 32'h1; mask = 32'h0000_00ff; end
      SZ_WORD:  begin step = 32'h2; mask = 32'h0000_ffff; end
      default:  begin step = 32'h4; mask = 32'hffff_ffff; end
    endcase
    e1m = e1_q & mask;
    cvm = cv_q & mask;
    rdm = mem_rdata & mask;
  end

  // next-state logic of the whole sequencer
  always_comb begin
    st_d   = st_q;
    cmd_d  = cmd_q;
    cnt_d  = cnt_q;
    p1_d   = p1_q;
    p2_d   = p2_q;
    tbl_d  = tbl_q;
    cv_d   = cv_q;
    e1_d   = e1_q;
    req_d  = req_q;
    mc_d   = mc_q;
    done_d = 1'b0;
    end_d  = end_q;
    eq_d   = eq_q;
    case (st_q)
      ST_IDLE: begin
        if (start) begin
          cmd_d = cmd;
          cnt_d = reg_count;
          p1_d  = reg_ptr1;
          p2_d  = reg_ptr2;
          tbl_d = reg_table;
          cv_d  = reg_cmpval;
          eq_d  = 1'b1;
          if (cmd.op == SSQ_OP_XLAT) cmd_d.size = SZ_BYTE;
          st_d  = ST_CHECK;
        end
      end
      ST_CHECK: begin
        // zero count ends before any memory access
        if (cnt_q == ZERO_WORD) begin
          end_d  = SSQ_END_COUNT;
          done_d = 1'b1;
          st_d   = ST_IDLE;
        end else begin
          req_d = 1'b1;
          mc_d  = '{write: 1'b0, size: cmd_q.size, addr: p1_q,
                    wdata: ZERO_WORD};
          st_d  = ST_RD1;
        end
      end
      ST_RD1: begin
        if (mem_ack) begin
          req_d = 1'b0;
          e1_d  = mem_rdata & mask;
          // option termination is judged on the string 1 element
          if (cmd_q.match == SSQ_MT_UNTIL && rdm == cvm) begin
            end_d  = SSQ_END_MATCH;
            done_d = 1'b1;
            st_d   = ST_IDLE;
          end else if (cmd_q.match == SSQ_MT_WHILE && rdm != cvm) begin
            end_d  = SSQ_END_DIFFER;
            done_d = 1'b1;
            st_d   = ST_IDLE;
          end else if (cmd_q.op == SSQ_OP_CMP) begin
            req_d = 1'b1;
            mc_d  = '{write: 1'b0, size: cmd_q.size, addr: p2_q,
                      wdata: ZERO_WORD};
            st_d  = ST_RD2;
          end else if (cmd_q.op == SSQ_OP_XLAT) begin
            req_d = 1'b1;
            mc_d  = '{write: 1'b0, size: SZ_BYTE,
                      addr: tbl_q + {24'h0, mem_rdata[7:0]},
                      wdata: ZERO_WORD};
            st_d  = ST_XLAT;
          end else begin
            req_d = 1'b1;
            mc_d  = '{write: 1'b1, size: cmd_q.size, addr: p2_q,
                      wdata: mem_rdata & mask};
            st_d  = ST_WR;
          end
        end
      end
      ST_RD2: begin
        if (mem_ack) begin
          req_d = 1'b0;
          // a mismatch ends the compare with the pointers on it
          if (rdm != e1m) begin
            eq_d   = 1'b0;
            end_d  = SSQ_END_DIFFER;
            done_d = 1'b1;
            st_d   = ST_IDLE;
          end else begin
            st_d = ST_ADV;
          end
        end
      end
      ST_XLAT: begin
        if (mem_ack) begin
          req_d = 1'b1;
          mc_d  = '{write: 1'b1, size: SZ_BYTE, addr: p2_q,
                    wdata: {24'h0, mem_rdata[7:0]}};
          st_d  = ST_WR;
        end
      end
      ST_WR: begin
        if (mem_ack) begin
          req_d = 1'b0;
          st_d  = ST_ADV;
        end
      end
      ST_ADV: begin
        cnt_d = cnt_q - 32'h1;
        if (cmd_q.backward) begin
          p1_d = p1_q - step;
          p2_d = p2_q - step;
        end else begin
          p1_d = p1_q + step;
          p2_d = p2_q + step;
        end
        st_d = ST_CHECK;
      end
      default: st_d = ST_IDLE;
    endcase
    // registered so busy leaves a flip-flop, same timing as the state
    busy_d = (st_d != ST_IDLE);
  end

  // state registers; nothing here but storage
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q   <= ST_IDLE;
      cmd_q  <= '0;
      cnt_q  <= '0;
      p1_q   <= '0;
      p2_q   <= '0;
      tbl_q  <= '0;
      cv_q   <= '0;
      e1_q   <= '0;
      req_q  <= 1'b0;
      mc_q   <= '0;
      done_q <= 1'b0;
      end_q  <= SSQ_END_COUNT;
      eq_q   <= 1'b1;
      busy_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cmd_q  <= cmd_d;
      cnt_q  <= cnt_d;
      p1_q   <= p1_d;
      p2_q   <= p2_d;
      tbl_q  <= tbl_d;
      cv_q   <= cv_d;
      e1_q   <= e1_d;
      req_q  <= req_d;
      mc_q   <= mc_d;
      done_q <= done_d;
      end_q  <= end_d;
      eq_q   <= eq_d;
      busy_q <= busy_d;
    end
  end

  // outputs straight from flip-flops
  assign mem_req   = req_q;
  assign mem_cmd   = mc_q;
  assign busy      = busy_q;
  assign done      = done_q;
  assign end_cause = end_q;
  assign cmp_equal = eq_q;
  assign wb_count  = cnt_q;
  assign wb_ptr1   = p1_q;
  assign wb_ptr2   = p2_q;

  // checks on the sequencing
  a_ptr_backward: assert property (@(posedge mclk) disable iff (!rst_b)
    st_q == ST_ADV && cmd_q.backward |=> p1_q == $past(p1_q) - $past(step))
    else $error("backward step did not lower pointer 1");
  a_ptr_forward: assert property (@(posedge mclk) disable iff (!rst_b)
    st_q == ST_ADV && !cmd_q.backward |=> p2_q == $past(p2_q) + $past(step))
    else $error("forward step did not raise pointer 2");
  a_until_stop: assert property (@(posedge mclk) disable iff (!rst_b)
    st_q == ST_RD1 && mem_ack && cmd_q.match == SSQ_MT_UNTIL && rdm == cvm
    |=> done && end_cause == SSQ_END_MATCH && st_q == ST_IDLE)
    else $error("until match did not stop");
  a_while_stop: assert property (@(posedge mclk) disable iff (!rst_b)
    st_q == ST_RD1 && mem_ack && cmd_q.match == SSQ_MT_WHILE && rdm != cvm
    |=> done && end_cause == SSQ_END_DIFFER)
    else $error("while match did not stop");
  a_count_step: assert property (@(posedge mclk) disable iff (!rst_b)
    st_q == ST_ADV |=> cnt_q == $past(cnt_q) - 32'h1)
    else $error("count not decremented");
  a_count_end: assert property (@(posedge mclk) disable iff (!rst_b)
    st_q == ST_CHECK && cnt_q == ZERO_WORD |=> done && !busy)
    else $error("zero count did not end");
  a_xlat_write: assert property (@(posedge mclk) disable iff (!rst_b)
    st_q == ST_XLAT && mem_ack
    |=> mem_req && mem_cmd.write && mem_cmd.addr == p2_q
        && mem_cmd.wdata[7:0] == $past(mem_rdata[7:0]))
    else $error("translated byte not written");
  a_cmp_differ: assert property (@(posedge mclk) disable iff (!rst_b)
    st_q == ST_RD2 && mem_ack && rdm != e1m |=> done && !cmp_equal)
    else $error("compare mismatch not ended");
  a_reg_load: assert property (@(posedge mclk) disable iff (!rst_b)
    st_q == ST_IDLE && start |=> cnt_q == $past(reg_count)
    && cv_q == $past(reg_cmpval))
    else $error("string registers not loaded");

  c_move_done: cover property (@(posedge mclk) disable iff (!rst_b)
    done && cmd_q.op == SSQ_OP_MOVE && end_cause == SSQ_END_COUNT);
  c_xlat_done: cover property (@(posedge mclk) disable iff (!rst_b)
    done && cmd_q.op == SSQ_OP_XLAT);
  c_cmp_diff: cover property (@(posedge mclk) disable iff (!rst_b)
    done && cmd_q.op == SSQ_OP_CMP && !cmp_equal);
  c_until_hit: cover property (@(posedge mclk) disable iff (!rst_b)
    done && end_cause == SSQ_END_MATCH);

endmodule
`default_nettype wire

// [include/ssq_pkg.sv]
// Purpose: shared types and constants for the string sequencer
// Assumes: byte/word/double element sizes, 32-bit registers
// Notes:   register indices follow the string register assignment
package ssq_pkg;

  localparam int unsigned DW          = 32;
  // general-purpose register indices used by string instructions
  localparam logic [2:0]  REG_COUNT   = 3'h0;
  localparam logic [2:0]  REG_PTR1    = 3'h1;
  localparam logic [2:0]  REG_PTR2    = 3'h2;
  localparam logic [2:0]  REG_TABLE   = 3'h3;
  localparam logic [2:0]  REG_CMPVAL  = 3'h4;
  // element size codes
  localparam logic [1:0]  SZ_BYTE     = 2'h0;
  localparam logic [1:0]  SZ_WORD     = 2'h1;
  localparam logic [1:0]  SZ_DOUBLE   = 2'h3;
  localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;

  typedef enum logic [1:0] {
    SSQ_OP_MOVE,
    SSQ_OP_XLAT,
    SSQ_OP_CMP
  } ssq_op_t;

  // match termination selection
  typedef enum logic [1:0] {
    SSQ_MT_NONE,
    SSQ_MT_UNTIL,
    SSQ_MT_WHILE
  } ssq_match_t;

  // instruction start request
  typedef struct packed {
    ssq_op_t    op;
    logic [1:0] size;
    logic       backward;
    ssq_match_t match;
  } ssq_cmd_t;

  // memory request towards the bus interface
  typedef struct packed {
    logic        write;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ssq_mreq_t;

  // how the instruction ended
  typedef enum logic [1:0] {
    SSQ_END_COUNT,
    SSQ_END_MATCH,
    SSQ_END_DIFFER
  } ssq_end_t;

endpackage

// [sim/ssq_mem_model.sv]
// Purpose: behavioural memory answering the sequencer's requests
// Assumes: 512 bytes, little-endian, address wraps on the low 9 bits
// Notes:   lag adds wait cycles before each acknowledge
`timescale 1ns/1ps
`default_nettype none
module ssq_mem_model
  import ssq_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // request side
  input  wire logic       mem_req,
  input  wire ssq_mreq_t  mem_cmd,
  output logic            mem_ack,
  output logic [31:0]     mem_rdata,
  // stall control
  input  wire logic [1:0] lag
);
  logic [7:0] mem [0:511];
  logic [1:0] wait_q;
  logic [8:0] a;

  assign a = mem_cmd.addr[8:0];

  // one ack per request; read lines scrambled when not answering, so a
  // sequencer that samples data outside the ack cycle sees garbage
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mem_ack   <= 1'b0;
      wait_q    <= 2'h0;
      mem_rdata <= 32'h0;
    end else if (mem_ack || !mem_req) begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (wait_q != lag) begin
      wait_q    <= wait_q + 2'h1;
      mem_rdata <= ~mem_rdata;
    end else begin
      wait_q    <= 2'h0;
      mem_ack   <= 1'b1;
      mem_rdata <= {mem[a + 9'h3], mem[a + 9'h2], mem[a + 9'h1], mem[a]};
      if (mem_cmd.write) begin
        mem[a] <= mem_cmd.wdata[7:0];
        if (mem_cmd.size != SZ_BYTE) mem[a + 9'h1] <= mem_cmd.wdata[15:8];
        if (mem_cmd.size[1]) mem[a + 9'h2] <= mem_cmd.wdata[23:16];
        if (mem_cmd.size[1]) mem[a + 9'h3] <= mem_cmd.wdata[31:24];
      end
    end
  end
endmodule
`default_nettype wire

// [sim/string_instruction_sequencer_test.sv]
// Purpose: self-checking bench for the string sequencer
// Assumes: memory byte at address a holds a + 0x80 * a[8] after init
// Notes:   translation table sits at 0x100, so entry b reads b + 0x80
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin \
  mismatches++; \
  $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp); end end
module string_instruction_sequencer_test
  import ssq_pkg::*;
;
  logic mclk, rst_b, start, mem_req, mem_ack, busy, done, cmp_equal;
  ssq_cmd_t  cmd;
  ssq_mreq_t mem_cmd;
  ssq_end_t  end_cause;
  logic [31:0] reg_count, reg_ptr1, reg_ptr2, reg_cmpval, mem_rdata;
  logic [31:0] wb_count, wb_ptr1, wb_ptr2, reg_table;
  logic [1:0]  lag;
  int mismatches, total_checks, cyc;

  ssq_sequencer dut (.mclk(mclk), .rst_b(rst_b), .start(start),
    .cmd(cmd), .reg_count(reg_count), .reg_ptr1(reg_ptr1),
    .reg_ptr2(reg_ptr2), .reg_table(reg_table),
    .reg_cmpval(reg_cmpval), .mem_req(mem_req), .mem_cmd(mem_cmd),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy), .done(done),
    .end_cause(end_cause), .cmp_equal(cmp_equal), .wb_count(wb_count),
    .wb_ptr1(wb_ptr1), .wb_ptr2(wb_ptr2));
  ssq_mem_model u_mem (.mclk(mclk), .rst_b(rst_b), .mem_req(mem_req),
    .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .lag(lag));

  // clock at 40 MHz
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic fill;
    for (int i = 0; i < 512; i++) u_mem.mem[i] = i[7:0] + {i[8], 7'h0};
  endtask

  // start one instruction and wait, bounded, for its done pulse
  task automatic run(input ssq_op_t op, input logic [1:0] sz,
    input logic bk, input ssq_match_t mt, input logic [31:0] n,
    input logic [31:0] p1, input logic [31:0] p2, input logic [31:0] cv);
    @(posedge mclk);
    #2;
    cmd = '{op, sz, bk, mt};
    reg_count = n;
    reg_ptr1 = p1;
    reg_ptr2 = p2;
    reg_cmpval = cv;
    start = 1'b1;
    @(posedge mclk);
    #2;
    start = 1'b0;
    `CHK(busy, 1'b1)
    cyc = 0;
    do begin
      @(posedge mclk);
      #2;
      cyc++;
    end while (done !== 1'b1 && cyc < 300);
    `CHK(done, 1'b1)
    `CHK(busy, 1'b0)
  endtask

  task automatic t_move_fwd;
    fill();
    run(SSQ_OP_MOVE, SZ_BYTE, 1'b0, SSQ_MT_NONE, 32'h3, 32'h10, 32'h40, 0);
    for (int i = 0; i < 3; i++)
      `CHK(u_mem.mem[9'h40 + i], 8'h10 + i[7:0])
    `CHK(u_mem.mem[9'h43], 8'h43)
    `CHK(wb_count, 32'h0)
    `CHK(wb_ptr1, 32'h13)
    `CHK(wb_ptr2, 32'h43)
    `CHK(end_cause, SSQ_END_COUNT)
  endtask

  // slow memory while stepping words downward
  task automatic t_move_back;
    fill();
    lag = 2'h2;
    run(SSQ_OP_MOVE, SZ_WORD, 1'b1, SSQ_MT_NONE, 32'h2, 32'h14, 32'h34, 0);
    lag = 2'h0;
    `CHK({u_mem.mem[9'h35], u_mem.mem[9'h34]}, 16'h1514)
    `CHK({u_mem.mem[9'h33], u_mem.mem[9'h32]}, 16'h1312)
    `CHK(wb_ptr1, 32'h10)
    `CHK(wb_ptr2, 32'h30)
    `CHK(wb_count, 32'h0)
  endtask

  task automatic t_xlat;
    fill();
    run(SSQ_OP_XLAT, SZ_BYTE, 1'b0, SSQ_MT_NONE, 32'h3, 32'h20, 32'h50, 0);
    for (int i = 0; i < 3; i++)
      `CHK(u_mem.mem[9'h50 + i], 8'ha0 + i[7:0])
    `CHK(u_mem.mem[9'h53], 8'h53)
    `CHK(wb_ptr2, 32'h53)
  endtask

  task automatic t_match;
    fill();
    run(SSQ_OP_MOVE, SZ_BYTE, 1'b0, SSQ_MT_UNTIL, 32'h5, 32'h10, 32'h40,
      32'h12);
    `CHK(end_cause, SSQ_END_MATCH)
    `CHK(wb_count, 32'h3)
    `CHK(wb_ptr1, 32'h12)
    `CHK(u_mem.mem[9'h42], 8'h42)
    run(SSQ_OP_MOVE, SZ_BYTE, 1'b0, SSQ_MT_WHILE, 32'h5, 32'h10, 32'h40,
      32'h10);
    `CHK(end_cause, SSQ_END_DIFFER)
    `CHK(wb_count, 32'h4)
    `CHK(wb_ptr1, 32'h11)
  endtask

  // mismatch on the second double word, then an equal single step
  task automatic t_cmp;
    fill();
    for (int i = 0; i < 4; i++) u_mem.mem[9'h60 + i] = 8'h20 + i[7:0];
    run(SSQ_OP_CMP, SZ_DOUBLE, 1'b0, SSQ_MT_NONE, 32'h3, 32'h20, 32'h60, 0);
    `CHK(end_cause, SSQ_END_DIFFER)
    `CHK(cmp_equal, 1'b0)
    `CHK(wb_count, 32'h2)
    `CHK(wb_ptr1, 32'h24)
    `CHK(wb_ptr2, 32'h64)
    run(SSQ_OP_CMP, SZ_DOUBLE, 1'b0, SSQ_MT_NONE, 32'h1, 32'h20, 32'h60, 0);
    `CHK(end_cause, SSQ_END_COUNT)
    `CHK(cmp_equal, 1'b1)
    `CHK(wb_count, 32'h0)
    // compare under until-match: equal first byte, stop on the second
    run(SSQ_OP_CMP, SZ_BYTE, 1'b0, SSQ_MT_UNTIL, 32'h4, 32'h20, 32'h60,
      32'h21);
    `CHK(end_cause, SSQ_END_MATCH)
    `CHK(cmp_equal, 1'b1)
    `CHK(wb_count, 32'h3)
    `CHK(wb_ptr2, 32'h61)
  endtask

  task automatic t_zero;
    run(SSQ_OP_MOVE, SZ_DOUBLE, 1'b0, SSQ_MT_NONE, 32'h0, 32'h10, 32'h40, 0);
    `CHK(cyc, 1)
    `CHK(wb_ptr1, 32'h10)
    `CHK(wb_count, 32'h0)
  endtask

  // watchdog well beyond the roughly 150 cycles the scenarios need
  initial begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    end_of_test();
  end

  initial begin
    rst_b = 1'b0;
    start = 1'b0;
    lag = 2'h0;
    cmd = '{SSQ_OP_MOVE, SZ_BYTE, 1'b0, SSQ_MT_NONE};
    {reg_count, reg_ptr1, reg_ptr2, reg_cmpval} = '0;
    reg_table = 32'h0000_0100;
    repeat (12) @(posedge mclk);
    #2;
    rst_b = 1'b1;
    t_move_fwd();
    t_move_back();
    t_xlat();
    t_match();
    t_cmp();
    t_zero();
    end_of_test();
  end
endmodule
`default_nettype wire
